// File: verilog/dmacf_pkg.sv
// constants for the dma channel control and status block
package dmacf_pkg;
  // register byte offsets on the axi4-lite bus
  localparam logic [4:0] DMACF_OFF_CTRL = 5'h00;
  localparam logic [4:0] DMACF_OFF_STAT = 5'h04;
  localparam logic [4:0] DMACF_OFF_SRC = 5'h08;
  localparam logic [4:0] DMACF_OFF_DST = 5'h0C;
  localparam logic [4:0] DMACF_OFF_CNT = 5'h10;
  localparam logic [4:0] DMACF_OFF_LIM = 5'h14;
  localparam logic [4:0] DMACF_OFF_MOD = 5'h18;
  // channel_control fields
  localparam int DMACF_C_NULL_WRITE_MODE = 10;
  localparam int DMACF_C_RELOAD = 9;
  localparam int DMACF_C_SWREQ = 8;
  localparam int DMACF_C_SRC_LO = 6;
  localparam int DMACF_C_DST_LO = 4;
  localparam int DMACF_C_TRM_LO = 2;
  localparam int DMACF_C_SIZE = 1;
  localparam int DMACF_C_EN = 0;
  localparam logic [15:0] DMACF_CTRL_WMASK = 16'h07FF;
  // channel_interrupt_status fields
  localparam int DMACF_S_BUFW = 15;
  localparam int DMACF_S_TSEL_LO = 8;
  localparam int DMACF_S_HIGH = 7;
  localparam int DMACF_S_LOW = 6;
  localparam int DMACF_S_DONE = 5;
  localparam int DMACF_S_HALF = 4;
  localparam int DMACF_S_OVRUN = 3;
  localparam int DMACF_S_HALFWAY_IRQ_ENABLE = 0;
  localparam logic [15:0] DMACF_STAT_WMASK = 16'h7FF9;
  // reset values
  localparam logic [15:0] DMACF_CTRL_RST = 16'h0000;
  localparam logic [15:0] DMACF_STAT_RST = 16'h0000;
  localparam logic [15:0] DMACF_LIM_HI_RST = 16'hFFFF;
  localparam logic [15:0] DMACF_LIM_LO_RST = 16'h0800;
  // top of the special-function region
  localparam logic [15:0] DMACF_SFR_TOP = 16'h07FF;
  localparam logic [1:0] DMACF_RESP_OKAY = 2'b00;
  localparam logic [1:0] DMACF_RESP_SLVERR = 2'b10;
  // stepping codes
  localparam logic [1:0] DMACF_STEP_KEEP = 2'b00;
  localparam logic [1:0] DMACF_STEP_INC = 2'b01;
  localparam logic [1:0] DMACF_STEP_DEC = 2'b10;
  localparam logic [1:0] DMACF_STEP_PIA = 2'b11;
  // transfer modes
  localparam logic [1:0] DMACF_TRM_ONE = 2'b00;
  localparam logic [1:0] DMACF_TRM_RONE = 2'b01;
  localparam logic [1:0] DMACF_TRM_CONT = 2'b10;
  localparam logic [1:0] DMACF_TRM_RCONT = 2'b11;
  typedef enum logic [4:0] {
    DMACF_IDLE = 5'b00001,
    DMACF_READ = 5'b00010,
    DMACF_WRITE = 5'b00100,
    DMACF_NULL = 5'b01000,
    DMACF_STEP = 5'b10000
  } dmacf_state_t;
endpackage

// File: verilog/dmacf_channel.sv
// one dma channel: control and status registers, sequencer, axi4-lite slave
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// - null-write mode adds a dummy write to source after each destination write
// - reload bit restores pointers and count at next operation start
// - repeated modes always restore pointers and count regardless of reload
// - only original count kept; original pointers rebuilt from it
// - software request starts transfer; hardware clears it on completion
// - transfers per software request follow the transfer mode
// - source step: keep, increment, decrement, or peripheral-indirect base; the code treats the peripheral-indirect code as keep
// - destination step uses the same four codes
// - transfer mode: one-shot, repeated one-shot, continuous, repeated continuous
// - size bit set means byte, clear means word; sets step size
// - channel acts on triggers only while channel enable is set
// - buffer write pending reads 1 while buffered data not yet written
// - seven-bit trigger select picks the interrupt source that triggers
// - upper limit flag on access above upper limit
// - lower limit flag on access below lower limit yet above sfr region
// - done flag set on completion; cleared when a new session starts
// - halfway flag set when count has counted halfway to zero
// - overrun flag set when triggered while previous operation runs
// - halfway enable adds an interrupt at halfway besides completion
// - software setting a status flag raises no interrupt
// - limit check made only when the access is really attempted
// - limit violation ends the transaction and raises an interrupt
// - clearing module enable aborts every active channel operation
module dmacf_channel
  import dmacf_pkg::*;
#(
  parameter int TRIG_W = 7,
  parameter int NUM_TRIG = 128
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_TRIG-1:0] trig_in,
  output logic mem_req,
  output logic mem_we,
  output logic mem_byte,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  output logic chan_irq
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [15:0] ctrl_q, stat_q, src_q, dst_q, cnt_q, cnt_orig_q;
  logic [15:0] lim_hi_q, lim_lo_q, buf_q, done_cnt_q;
  logic mod_en_q, arm_q, busy_q, irq_q;
  dmacf_state_t state_q, state_d;
  logic [4:0] awaddr_q;
  logic aw_hold_q, w_hold_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  logic [1:0] src_mode, dst_mode, trm;
  logic byte_mode, enable, trig_sel_hit, trig_evt, start, step_one;
  logic [15:0] step_sz, acc_addr;
  logic viol_hi, viol_lo, wr_fire, rd_fire, acc_done, last_xfer;
  logic half_hit, fin, abort;

  assign src_mode = ctrl_q[DMACF_C_SRC_LO+:2];
  assign dst_mode = ctrl_q[DMACF_C_DST_LO+:2];
  assign trm = ctrl_q[DMACF_C_TRM_LO+:2];
  assign byte_mode = ctrl_q[DMACF_C_SIZE];
  assign step_sz = byte_mode ? 16'h0001 : 16'h0002;
  assign enable = ctrl_q[DMACF_C_EN] & mod_en_q;
  assign abort = ~enable & busy_q;

  // step a pointer by its two-bit code
  function automatic logic [15:0] dmacf_step(input logic [15:0] p,
      input logic [1:0] m, input logic [15:0] s);
    logic [15:0] r;
    r = p;
    unique case (m)
      DMACF_STEP_INC: r = p + s;
      DMACF_STEP_DEC: r = p - s;
      default: r = p;
    endcase
    return r;
  endfunction

  // undo n steps of a pointer; lets reload work from the count alone
  function automatic logic [15:0] dmacf_unstep(input logic [15:0] p,
      input logic [1:0] m, input logic [15:0] s, input logic [15:0] n);
    logic [15:0] d;
    d = 16'(s * n);
    unique case (m)
      DMACF_STEP_INC: return p - d;
      DMACF_STEP_DEC: return p + d;
      default: return p;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // trigger and sequencer
  // ---------------------------------------------------------------
  logic [TRIG_W-1:0] tsel;
  assign tsel = stat_q[DMACF_S_TSEL_LO+:TRIG_W];
  // code zero is off
  assign trig_sel_hit = (tsel != '0) & trig_in[tsel];
  assign trig_evt = enable & (trig_sel_hit | ctrl_q[DMACF_C_SWREQ]);
  assign start = trig_evt & ~busy_q & (arm_q | trm[0]);
  // one-shot modes move one item per trigger, continuous modes the count
  assign step_one = ~trm[1];
  assign acc_addr = (state_q == DMACF_READ) ? src_q : dst_q;
  // check made on the address being presented, never ahead of time
  assign viol_hi = mem_req & (mem_addr > lim_hi_q);
  assign viol_lo = mem_req & (mem_addr < lim_lo_q) &
                   (mem_addr > DMACF_SFR_TOP);
  assign acc_done = mem_req & mem_ack;
  assign last_xfer = (cnt_q <= 16'h0001);
  assign half_hit = (state_q == DMACF_STEP) &
                    (cnt_q - 16'h0001 == cnt_orig_q >> 1);
  assign fin = (state_q == DMACF_STEP) & (last_xfer | step_one);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      DMACF_IDLE: if (start) state_d = DMACF_READ;
      DMACF_READ: if (acc_done) state_d = DMACF_WRITE;
      DMACF_WRITE: begin
        if (acc_done) begin
          state_d = ctrl_q[DMACF_C_NULL_WRITE_MODE] ? DMACF_NULL : DMACF_STEP;
        end
      end
      DMACF_NULL: if (acc_done) state_d = DMACF_STEP;
      DMACF_STEP: begin
        state_d = (step_one | last_xfer) ? DMACF_IDLE : DMACF_READ;
      end
    endcase
    if (abort | viol_hi | viol_lo) begin
      state_d = DMACF_IDLE;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= DMACF_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // busy spans a whole session: one item or a full count
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
    end else if (start) begin
      busy_q <= 1'b1;
    end else if (state_d == DMACF_IDLE) begin
      busy_q <= 1'b0;
    end
  end

  // non-repeated modes without reload stop after the count completes, until re-armed
  logic reload_now;
  assign reload_now = start & (ctrl_q[DMACF_C_RELOAD] | trm[0]) &
                      (cnt_q == 16'h0000);

  assign mem_req = (state_q == DMACF_READ) | (state_q == DMACF_WRITE) |
                   (state_q == DMACF_NULL);
  assign mem_we = (state_q != DMACF_READ);
  assign mem_byte = byte_mode;
  assign mem_addr = (state_q == DMACF_NULL) ? src_q : acc_addr;
  assign mem_wdata = buf_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      buf_q <= 16'h0000;
    end else if (state_q == DMACF_READ && acc_done) begin
      buf_q <= mem_rdata;
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_fire = aw_hold_q & w_hold_q;
  assign rd_fire = s_axi_arvalid & s_axi_arready;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 5'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= DMACF_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q > DMACF_OFF_MOD || awaddr_q[1:0] != 2'b00)
                       ? DMACF_RESP_SLVERR : DMACF_RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // byte-lane merge of the low half word
  function automatic logic [15:0] dmacf_merge(input logic [15:0] old,
      input logic [15:0] nw, input logic [1:0] st);
    return {st[1] ? nw[15:8] : old[15:8], st[0] ? nw[7:0] : old[7:0]};
  endfunction

  logic [15:0] wv;
  logic w_ctrl, w_stat, w_src, w_dst, w_cnt, w_lim, w_mod;
  assign wv = wdata_q[15:0];
  assign w_ctrl = wr_fire & (awaddr_q == DMACF_OFF_CTRL);
  assign w_stat = wr_fire & (awaddr_q == DMACF_OFF_STAT);
  assign w_src = wr_fire & (awaddr_q == DMACF_OFF_SRC);
  assign w_dst = wr_fire & (awaddr_q == DMACF_OFF_DST);
  assign w_cnt = wr_fire & (awaddr_q == DMACF_OFF_CNT);
  assign w_lim = wr_fire & (awaddr_q == DMACF_OFF_LIM);
  assign w_mod = wr_fire & (awaddr_q == DMACF_OFF_MOD);

  // control; reserved and unimplemented bits hold zero
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= DMACF_CTRL_RST;
    end else begin
      if (w_ctrl) begin
        ctrl_q <= dmacf_merge(ctrl_q, wv, wstrb_q[1:0]) &
                  DMACF_CTRL_WMASK;
      end
      // a session cut by a limit violation retires the request too, else it retriggers itself
      if ((fin & (last_xfer | step_one)) | viol_hi | viol_lo) begin
        ctrl_q[DMACF_C_SWREQ] <= 1'b0;
      end
    end
  end

  // pointers and count; reload rebuilds pointers from the saved count
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      src_q <= 16'h0000;
      dst_q <= 16'h0000;
      cnt_q <= 16'h0000;
      cnt_orig_q <= 16'h0000;
      arm_q <= 1'b0;
    end else begin
      if (w_src) src_q <= dmacf_merge(src_q, wv, wstrb_q[1:0]);
      if (w_dst) dst_q <= dmacf_merge(dst_q, wv, wstrb_q[1:0]);
      if (w_cnt) begin
        cnt_q <= dmacf_merge(cnt_q, wv, wstrb_q[1:0]);
        cnt_orig_q <= dmacf_merge(cnt_q, wv, wstrb_q[1:0]);
        arm_q <= 1'b1;
      end
      if (reload_now) begin
        src_q <= dmacf_unstep(src_q, src_mode, step_sz, cnt_orig_q);
        dst_q <= dmacf_unstep(dst_q, dst_mode, step_sz, cnt_orig_q);
        cnt_q <= cnt_orig_q;
      end
      if (state_q == DMACF_STEP) begin
        src_q <= dmacf_step(src_q, src_mode, step_sz);
        dst_q <= dmacf_step(dst_q, dst_mode, step_sz);
        cnt_q <= cnt_q - 16'h0001;
        if (last_xfer && !trm[0] && !ctrl_q[DMACF_C_RELOAD]) begin
          arm_q <= 1'b0;
        end
      end
    end
  end

  // limits and module enable
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lim_hi_q <= DMACF_LIM_HI_RST;
      lim_lo_q <= DMACF_LIM_LO_RST;
      mod_en_q <= 1'b0;
    end else begin
      if (w_lim) begin
        if (wstrb_q[1:0] == 2'b11) lim_lo_q <= wv;
        if (wstrb_q[3:2] == 2'b11) lim_hi_q <= wdata_q[31:16];
      end
      if (w_mod && wstrb_q[0]) mod_en_q <= wdata_q[0];
    end
  end

  // status: hardware set beats software clear in the same cycle
  logic [15:0] stat_sw, hw_set;
  logic last_done;
  assign last_done = fin & last_xfer;
  assign stat_sw = w_stat ? dmacf_merge(stat_q, wv, wstrb_q[1:0]) : stat_q;
  always_comb begin
    hw_set = 16'h0000;
    hw_set[DMACF_S_HIGH] = viol_hi;
    hw_set[DMACF_S_LOW] = viol_lo;
    hw_set[DMACF_S_DONE] = last_done;
    hw_set[DMACF_S_HALF] = half_hit;
    hw_set[DMACF_S_OVRUN] = trig_sel_hit & enable & busy_q;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stat_q <= DMACF_STAT_RST;
    end else begin
      stat_q <= ((stat_sw & DMACF_STAT_WMASK) | hw_set) &
                ~16'(start & (cnt_q != 16'h0000 | reload_now)
                     ? (16'h0001 << DMACF_S_DONE) : 16'h0000);
      stat_q[DMACF_S_BUFW] <= (state_d == DMACF_WRITE) |
                              (state_d == DMACF_NULL);
    end
  end

  // interrupt pulse only from hardware events, never from software writes
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= last_done | viol_hi | viol_lo |
               (half_hit & stat_q[DMACF_S_HALFWAY_IRQ_ENABLE]);
    end
  end
  assign chan_irq = irq_q;

  // read side
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= DMACF_RESP_OKAY;
      done_cnt_q <= 16'h0000;
    end else begin
      if (last_done) done_cnt_q <= done_cnt_q + 16'h0001;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= DMACF_RESP_OKAY;
        unique case (s_axi_araddr)
          DMACF_OFF_CTRL: s_axi_rdata <= {16'h0000, ctrl_q};
          DMACF_OFF_STAT: s_axi_rdata <= {16'h0000, stat_q};
          DMACF_OFF_SRC: s_axi_rdata <= {16'h0000, src_q};
          DMACF_OFF_DST: s_axi_rdata <= {16'h0000, dst_q};
          DMACF_OFF_CNT: s_axi_rdata <= {16'h0000, cnt_q};
          DMACF_OFF_LIM: s_axi_rdata <= {lim_hi_q, lim_lo_q};
          DMACF_OFF_MOD: s_axi_rdata <= {done_cnt_q, 15'h0000, mod_en_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= DMACF_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// File: dv/dmacf_chk_assertions.sv
// port-level assertion checker for the dma channel
`timescale 1ns/1ps
module dmacf_chk (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic mem_ack,
  input wire logic chan_irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_write_resp: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write response missing");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_aw_refused: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  // a limit violation may withdraw a request without acknowledge
  a_mem_hold: assert property (mem_req && !mem_ack
    |=> (mem_req && $stable(mem_addr) && $stable(mem_we))
    or (1'b1 ##[0:1] chan_irq)) else $error("memory request unstable");
  a_irq_pulse: assert property (chan_irq |=> !chan_irq)
    else $error("interrupt longer than one cycle");
  a_read_first: assert property ($rose(mem_req) |-> !mem_we)
    else $error("transfer did not start with a read");
  a_write_next: assert property (mem_req && !mem_we && mem_ack
    |=> mem_req && mem_we) else $error("no write after read");
endmodule

// File: dv/dmacf_mem_model.sv
// data-space partner model answering the channel's accesses
`timescale 1ns/1ps
module dmacf_mem_model (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [3:0] stall,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [15:0] mem [0:255];
  logic [3:0] wait_q;
  logic [15:0] last_wa;
  int nwr;
  // plain always so the bench may preload the array
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mem_ack <= 1'b0;
      wait_q <= 4'h0;
      mem_rdata <= 16'h0000;
    end else begin
      mem_ack <= 1'b0;
      // stale read data keeps changing so it is never mistaken
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        if (wait_q < stall) begin
          wait_q <= wait_q + 4'h1;
        end else begin
          wait_q <= 4'h0;
          mem_ack <= 1'b1;
          if (mem_we) begin
            mem[mem_addr[8:1]] <= mem_wdata;
            nwr <= nwr + 1;
            last_wa <= mem_addr;
          end else begin
            mem_rdata <= mem[mem_addr[8:1]];
          end
        end
      end
    end
  end
endmodule

// File: dv/tb.sv
// self-checking bench for the dma channel
`timescale 1ns/1ps
module tb;
  import dmacf_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [4:0] s_axi_awaddr = 5'h00;
  logic [4:0] s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [127:0] trig_in = 128'h0;
  logic [3:0] stall = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rd;
  logic mem_req, mem_we, mem_byte, mem_ack, chan_irq;
  logic [15:0] mem_addr, mem_wdata, mem_rdata;
  int errors = 0, num_checks = 0, n0;
  always #50 mclk = ~mclk;
  dmacf_channel uut (.mclk, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trig_in, .mem_req,
    .mem_we, .mem_byte, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata,
    .chan_irq);
  dmacf_mem_model mem_m (.mclk, .reset_n, .stall, .mem_req, .mem_we,
    .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
  task final_report;
    $display("errors=%0d checks=%0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task hang;
    errors++;
    $display("CHECK FAILED t=%0t wait ran out", $time);
    final_report;
  endtask
  task wr(input logic [4:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    hb = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 50 && !hb; n++) begin
      @(negedge mclk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      @(posedge mclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!hb) hang();
  endtask
  task rdr(input logic [4:0] a);
    logic ha, hr;
    hr = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 50 && !hr; n++) begin
      @(negedge mclk);
      ha = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge mclk);
      if (ha) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!hr) hang();
  endtask
  task rchk(input logic [4:0] a, input logic [15:0] exp);
    rdr(a);
    chk(rd[15:0], exp);
  endtask
  task wirq;
    logic hit;
    hit = 1'b0;
    for (int n = 0; n < 600 && !hit; n++) begin
      @(negedge mclk);
      hit = chan_irq;
      @(posedge mclk);
    end
    if (!hit) hang();
  endtask
  task setup(input logic [15:0] s, input logic [15:0] d,
             input logic [15:0] c);
    wr(DMACF_OFF_SRC, {16'h0, s});
    wr(DMACF_OFF_DST, {16'h0, d});
    wr(DMACF_OFF_CNT, {16'h0, c});
  endtask
  task t_regs;
    rchk(DMACF_OFF_CTRL, 16'h0000);
    rchk(DMACF_OFF_STAT, 16'h0000);
    rdr(5'h1C);
    chk({14'h0, rs}, {14'h0, DMACF_RESP_SLVERR});
    // request set while disabled must stay pending, enable bit kept 0
    wr(DMACF_OFF_CTRL, 32'h07FE);
    rchk(DMACF_OFF_CTRL, 16'h07FE);
    wr(DMACF_OFF_CTRL, 32'h0);
    wr(DMACF_OFF_MOD, 32'h1);
  endtask
  task t_one;
    mem_m.mem[0] = 16'hA5C3;
    setup(16'h0800, 16'h0900, 16'h0001);
    wr(DMACF_OFF_CTRL, 32'h0151);
    wirq();
    chk(mem_m.mem[8'h80], 16'hA5C3);
    rchk(DMACF_OFF_SRC, 16'h0802);
    rchk(DMACF_OFF_DST, 16'h0902);
    rchk(DMACF_OFF_CTRL, 16'h0051);
    rdr(DMACF_OFF_STAT);
    chk({15'h0, rd[DMACF_S_DONE]}, 16'h0001);
    wr(DMACF_OFF_CTRL, 32'h0);
  endtask
  task t_null;
    stall <= 4'h2;
    n0 = mem_m.nwr;
    setup(16'h0810, 16'h0900, 16'h0002);
    wr(DMACF_OFF_CTRL, 32'h058B);
    wirq();
    chk(16'(mem_m.nwr - n0), 16'h0004);
    chk(mem_m.last_wa, 16'h080F);
    rchk(DMACF_OFF_SRC, 16'h080E);
    rchk(DMACF_OFF_DST, 16'h0900);
    rchk(DMACF_OFF_CTRL, 16'h048B);
    rdr(DMACF_OFF_STAT);
    chk({15'h0, rd[DMACF_S_HALF]}, 16'h0001);
    stall <= 4'h0;
    wr(DMACF_OFF_CTRL, 32'h0);
  endtask
  task t_limit;
    for (int i = 0; i < 2; i++) begin
      wr(DMACF_OFF_LIM, i ? 32'hFFFF0880 : 32'h08FF0800);
      setup(i ? 16'h0840 : 16'h0800, i ? 16'h0900 : 16'h0A00, 16'h0001);
      wr(DMACF_OFF_CTRL, 32'h0151);
      wirq();
      rdr(DMACF_OFF_STAT);
      chk({14'h0, rd[7:6]}, i ? 16'h0001 : 16'h0002);
      wr(DMACF_OFF_STAT, 32'h0);
      rchk(DMACF_OFF_STAT, 16'h0000);
      wr(DMACF_OFF_CTRL, 32'h0);
    end
    wr(DMACF_OFF_LIM, 32'hFFFF0800);
  endtask
  task t_reload;
    for (int i = 0; i < 2; i++) begin
      n0 = mem_m.nwr;
      setup(16'h0800, 16'h0900, 16'h0001);
      wr(DMACF_OFF_CTRL, i ? 32'h0155 : 32'h0351);
      wirq();
      wr(DMACF_OFF_CTRL, i ? 32'h0155 : 32'h0351);
      wirq();
      chk(16'(mem_m.nwr - n0), 16'h0002);
      rchk(DMACF_OFF_SRC, 16'h0802);
      wr(DMACF_OFF_CTRL, 32'h0);
    end
  endtask
  task t_trig;
    wr(DMACF_OFF_STAT, 32'h0500);
    trig_in <= 128'h20;
    n0 = mem_m.nwr;
    setup(16'h0800, 16'h0900, 16'h0001);
    wr(DMACF_OFF_CTRL, 32'h0050);
    repeat (20) @(posedge mclk);
    chk(16'(mem_m.nwr - n0), 16'h0000);
    wr(DMACF_OFF_CTRL, 32'h0051);
    wirq();
    chk(16'(mem_m.nwr - n0), 16'h0001);
    rdr(DMACF_OFF_MOD);
    chk(rd[31:16], 16'h0007);
    trig_in <= 128'h0;
    wr(DMACF_OFF_CTRL, 32'h0);
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_one();
    t_null();
    t_limit();
    t_reload();
    t_trig();
    final_report();
  end
endmodule
bind dmacf_channel dmacf_chk chk_i (.mclk, .reset_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .mem_req, .mem_we,
  .mem_addr, .mem_ack, .chan_irq);
